// ===== hdl/adc_mode_pkg.sv
// Constants for the converter power and mode controller.
// Assumes a 100 MHz core clock; all times are converted to cycles here.
package adc_mode_pkg;

  // Core clock rate and timer width
  localparam int CORE_MHZ = 100;
  localparam int TMR_W = 27;

  // Times as printed, at the 4.9152 MHz reference converter clock
  localparam real T_WAKE_INT_US = 7.95;
  localparam real T_WAKE_EXT_US = 0.16;
  localparam real T_WAKE_XTAL_MS = 5.6;
  localparam real T_PD_MIN_US = 26.0;
  localparam real T_ACT_FAST_MS = 12.46;
  localparam real T_ACT_SLOW_MS = 99.96;
  localparam real T_CAL_FAST_MS = 103.0;
  localparam real T_CAL_SLOW_MS = 803.0;
  localparam real T_NOCAL_FAST_MS = 52.51;
  localparam real T_NOCAL_SLOW_MS = 401.8;
  localparam real T_CONV_FAST_MS = 12.5;
  localparam real T_CONV_SLOW_MS = 100.0;

  // Cycle counts; tiny epsilon keeps exact products from rounding up
  localparam int CYC_WAKE_INT = int'($ceil(T_WAKE_INT_US * CORE_MHZ - 1.0e-6));
  localparam int CYC_WAKE_EXT = int'($ceil(T_WAKE_EXT_US * CORE_MHZ - 1.0e-6));
  localparam int CYC_WAKE_XTAL =
    int'($ceil(T_WAKE_XTAL_MS * 1000.0 * CORE_MHZ - 1.0e-6));
  localparam int CYC_PD_MIN = int'($ceil(T_PD_MIN_US * CORE_MHZ - 1.0e-6));
  localparam int CYC_ACT_FAST =
    int'($ceil(T_ACT_FAST_MS * 1000.0 * CORE_MHZ - 1.0e-6));
  localparam int CYC_ACT_SLOW =
    int'($ceil(T_ACT_SLOW_MS * 1000.0 * CORE_MHZ - 1.0e-6));
  localparam int CYC_CAL_FAST =
    int'($ceil(T_CAL_FAST_MS * 1000.0 * CORE_MHZ - 1.0e-6));
  localparam int CYC_CAL_SLOW =
    int'($ceil(T_CAL_SLOW_MS * 1000.0 * CORE_MHZ - 1.0e-6));
  localparam int CYC_NOCAL_FAST =
    int'($ceil(T_NOCAL_FAST_MS * 1000.0 * CORE_MHZ - 1.0e-6));
  localparam int CYC_NOCAL_SLOW =
    int'($ceil(T_NOCAL_SLOW_MS * 1000.0 * CORE_MHZ - 1.0e-6));
  localparam int CYC_CONV_FAST =
    int'($ceil(T_CONV_FAST_MS * 1000.0 * CORE_MHZ - 1.0e-6));
  localparam int CYC_CONV_SLOW =
    int'($ceil(T_CONV_SLOW_MS * 1000.0 * CORE_MHZ - 1.0e-6));

  // Serial clock pulses that request calibration on standby entry
  localparam logic [4:0] SCLK_CAL_CNT = 5'h19;

  // Gain codes and mux selections
  localparam logic [1:0] GAIN_128 = 2'h3;
  localparam logic [1:0] MUX_CH1 = 2'h0;
  localparam logic [1:0] MUX_CH2 = 2'h1;
  localparam logic [1:0] MUX_TEMP = 2'h2;

  // Clock source codes
  localparam logic [1:0] CLK_INT = 2'h0;
  localparam logic [1:0] CLK_EXT = 2'h1;
  localparam logic [1:0] CLK_XTAL = 2'h2;

  // Register offsets and reset values
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // Control field positions
  localparam int CTRL_OVR = 0;
  localparam int CTRL_GAIN = 1;
  localparam int CTRL_MUX = 3;
  localparam int CTRL_FAST = 5;

  // Status field positions
  localparam int ST_STATE = 0;
  localparam int ST_DRDY = 3;
  localparam int ST_ANALOG = 4;
  localparam int ST_CAL = 5;
  localparam int ST_CLK = 6;
  localparam int ST_PDSHORT = 8;
  localparam int ST_SCLKS = 9;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_OFF, MODE_WAKE, MODE_RUN, MODE_STBY, MODE_SETTLE
  } mode_t;

endpackage : adc_mode_pkg

// ===== hdl/pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes the pins are asynchronous to core_clk.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Pins in, filtered levels out
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_level
);

  logic [W-1:0] s1_r, s2_r, s3_r, lvl_r, lvl_nxt;

  // Level follows only once stages two and three agree
  always_comb begin
    lvl_nxt = ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & lvl_r);
  end

  // First stage feeds the second only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      lvl_r <= INIT;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign pin_level = lvl_r;

endmodule : pin_sync

// ===== hdl/adc_power_mode_control.sv
// Pin-driven power, standby and calibration sequencer with AHB-Lite view.
// Assumes all control pins are asynchronous; bus on core_clk.
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - 25 sclk pulses then sclk held high requests calibration after wake.
// - Calibrated wake gives data ready after 103 ms fast, 803 ms slow.
// - First result after calibrated wake is flagged fully settled.
// - Held in power-down with analog off while pin is low.
// - Power-down clears mode, timers, sclk count and cal request; strap picks, clock source and short flag are kept.
// - Power-down accepted at any moment, even mid-readout.
// - Wake from power-down after 7.95 us, 0.16 us or 5.6 ms by clock.
// - Power-down pulses shorter than 26 us are flagged.
// - Times scale with converter clock period, +-3% on internal oscillator; here fixed cycle counts at the 4.9152 MHz reference clock.
// - Both gain straps high select gain 128.
// - Channel and temp straps low pick channel 1; rate low picks 10 SPS.
// - Grounded clock input: internal; open crystal pin: external; else crystal.
// - Sclk low leaves standby; sclk high holds it.
// - Standby starts after sclk high 12.46 ms fast or 99.96 ms slow.
module adc_power_mode_control #(
  parameter int ACT_FAST = adc_mode_pkg::CYC_ACT_FAST,
  parameter int ACT_SLOW = adc_mode_pkg::CYC_ACT_SLOW,
  parameter int CAL_FAST = adc_mode_pkg::CYC_CAL_FAST,
  parameter int CAL_SLOW = adc_mode_pkg::CYC_CAL_SLOW,
  parameter int NOCAL_FAST = adc_mode_pkg::CYC_NOCAL_FAST,
  parameter int NOCAL_SLOW = adc_mode_pkg::CYC_NOCAL_SLOW,
  parameter int CONV_FAST = adc_mode_pkg::CYC_CONV_FAST,
  parameter int CONV_SLOW = adc_mode_pkg::CYC_CONV_SLOW,
  parameter int WAKE_XTAL = adc_mode_pkg::CYC_WAKE_XTAL
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Host control pins
  input wire logic sclk,
  input wire logic power_down_n_pin,
  // Strap pins
  input wire logic [1:0] gain_select,
  input wire logic channel_select,
  input wire logic temp_select,
  input wire logic rate_select,
  input wire logic clock_input_grounded,
  input wire logic crystal_output_open,
  // Converter controls
  output logic ready_and_result_out,
  output logic analog_on,
  output logic offset_cal_active,
  output logic result_settled,
  output logic [1:0] pga_gain,
  output logic [1:0] mux_channel,
  output logic rate_fast,
  output logic [1:0] clock_source,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  localparam int TW = adc_mode_pkg::TMR_W;
  localparam int PDW = 12;

  // Synchronised pins
  logic [8:0] pins_s;
  logic sclk_s, pd_n_s, chan_s, temp_s, rate_s, gnd_s, open_s;
  logic [1:0] gain_s;

  pin_sync #(.W(9), .INIT(9'h000)) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin_in({sclk, power_down_n_pin, gain_select, channel_select,
             temp_select, rate_select, clock_input_grounded,
             crystal_output_open}),
    .pin_level(pins_s)
  );
  assign {sclk_s, pd_n_s, gain_s, chan_s, temp_s, rate_s, gnd_s, open_s} =
    pins_s;

  // Bus state
  logic [31:0] ctrl_r, ctrl_nxt, hrdata_r, hrdata_nxt;
  logic wr_pend_r, wr_pend_nxt, hreadyout_r;
  logic [7:0] wr_addr_r, wr_addr_nxt;
  logic pd_short_clr;

  // Mode state
  adc_mode_pkg::mode_t mode_r, mode_nxt;
  logic [TW-1:0] tmr_r, tmr_nxt, hi_r, hi_nxt, dwell_r, dwell_nxt;
  logic [PDW-1:0] pd_low_r, pd_low_nxt;
  logic [4:0] sclks_r, sclks_nxt;
  logic sclk_d_r, cal_r, cal_nxt, pd_short_r, pd_short_nxt;
  logic drdy_r, drdy_nxt, settled_r, settled_nxt;
  logic analog_r, analog_nxt, cal_act_r, cal_act_nxt;
  logic [1:0] gain_r, gain_nxt, mux_r, mux_nxt, src_r, src_nxt;
  logic fast_r, fast_nxt;
  logic [TW-1:0] act_cyc, conv_cyc, settle_cyc, wake_cyc;

  // Figures picked by rate and clock source
  always_comb begin
    act_cyc = fast_r ? TW'(ACT_FAST) : TW'(ACT_SLOW);
    conv_cyc = fast_r ? TW'(CONV_FAST) : TW'(CONV_SLOW);
    if (cal_r) begin
      settle_cyc = fast_r ? TW'(CAL_FAST) : TW'(CAL_SLOW);
    end else begin
      settle_cyc = fast_r ? TW'(NOCAL_FAST) : TW'(NOCAL_SLOW);
    end
    unique case (src_nxt)
      adc_mode_pkg::CLK_EXT: wake_cyc = TW'(adc_mode_pkg::CYC_WAKE_EXT);
      adc_mode_pkg::CLK_XTAL: wake_cyc = TW'(WAKE_XTAL);
      default: wake_cyc = TW'(adc_mode_pkg::CYC_WAKE_INT);
    endcase
  end

  // Mode sequencer next state
  always_comb begin
    mode_nxt = mode_r;
    tmr_nxt = tmr_r;
    hi_nxt = hi_r;
    pd_low_nxt = pd_low_r;
    sclks_nxt = sclks_r;
    cal_nxt = cal_r;
    drdy_nxt = drdy_r;
    settled_nxt = settled_r;
    gain_nxt = gain_r;
    mux_nxt = mux_r;
    src_nxt = src_r;
    fast_nxt = fast_r;
    pd_short_nxt = pd_short_r & ~pd_short_clr;
    if (!pd_n_s) begin
      // Low pin wins over every mode, even mid-readout
      mode_nxt = adc_mode_pkg::MODE_OFF;
      tmr_nxt = '0;
      hi_nxt = '0;
      sclks_nxt = '0;
      cal_nxt = 1'b0;
      drdy_nxt = 1'b1;
      settled_nxt = 1'b0;
      if (pd_low_r != PDW'(adc_mode_pkg::CYC_PD_MIN)) begin
        pd_low_nxt = pd_low_r + PDW'(1);
      end
    end else begin
      unique case (mode_r)
        adc_mode_pkg::MODE_OFF: begin
          // Straps are caught as power-down is released
          if (ctrl_r[adc_mode_pkg::CTRL_OVR]) begin
            gain_nxt = ctrl_r[adc_mode_pkg::CTRL_GAIN +: 2];
            mux_nxt = ctrl_r[adc_mode_pkg::CTRL_MUX +: 2];
            fast_nxt = ctrl_r[adc_mode_pkg::CTRL_FAST];
          end else begin
            gain_nxt = gain_s;
            mux_nxt = temp_s ? adc_mode_pkg::MUX_TEMP :
                      (chan_s ? adc_mode_pkg::MUX_CH2 :
                       adc_mode_pkg::MUX_CH1);
            fast_nxt = rate_s;
          end
          if (gnd_s) begin
            src_nxt = adc_mode_pkg::CLK_INT;
          end else if (open_s) begin
            src_nxt = adc_mode_pkg::CLK_EXT;
          end else begin
            src_nxt = adc_mode_pkg::CLK_XTAL;
          end
          if (pd_low_r < PDW'(adc_mode_pkg::CYC_PD_MIN)) begin
            pd_short_nxt = 1'b1;
          end
          pd_low_nxt = '0;
          tmr_nxt = wake_cyc - TW'(1);
          mode_nxt = adc_mode_pkg::MODE_WAKE;
        end
        adc_mode_pkg::MODE_WAKE: begin
          if (tmr_r == '0) begin
            tmr_nxt = conv_cyc - TW'(1);
            mode_nxt = adc_mode_pkg::MODE_RUN;
          end else begin
            tmr_nxt = tmr_r - TW'(1);
          end
        end
        adc_mode_pkg::MODE_RUN: begin
          // Conversion clock keeps going during readout
          if (tmr_r == '0) begin
            tmr_nxt = conv_cyc - TW'(1);
            drdy_nxt = 1'b0;
            sclks_nxt = '0;
            settled_nxt = 1'b0;
          end else begin
            tmr_nxt = tmr_r - TW'(1);
          end
          if (sclk_s && !sclk_d_r) begin
            drdy_nxt = 1'b1;
            settled_nxt = 1'b0;
            if (sclks_r != 5'h1f) begin
              sclks_nxt = sclks_r + 5'h01;
            end
          end
          if (sclk_s) begin
            if (hi_r == act_cyc - TW'(1)) begin
              mode_nxt = adc_mode_pkg::MODE_STBY;
              // The hold rise is counted too, so 25 pulses read as 26
              cal_nxt = (sclks_r == adc_mode_pkg::SCLK_CAL_CNT + 5'h01);
              drdy_nxt = 1'b1;
              hi_nxt = '0;
            end else begin
              hi_nxt = hi_r + TW'(1);
            end
          end else begin
            hi_nxt = '0;
          end
        end
        adc_mode_pkg::MODE_STBY: begin
          if (!sclk_s) begin
            mode_nxt = adc_mode_pkg::MODE_SETTLE;
            tmr_nxt = settle_cyc - TW'(1);
            sclks_nxt = '0;
          end
        end
        adc_mode_pkg::MODE_SETTLE: begin
          drdy_nxt = 1'b1;
          if (tmr_r == '0) begin
            mode_nxt = adc_mode_pkg::MODE_RUN;
            tmr_nxt = conv_cyc - TW'(1);
            drdy_nxt = 1'b0;
            settled_nxt = cal_r;
            cal_nxt = 1'b0;
          end else begin
            tmr_nxt = tmr_r - TW'(1);
          end
        end
        default: mode_nxt = adc_mode_pkg::MODE_OFF;
      endcase
    end
    analog_nxt = (mode_nxt == adc_mode_pkg::MODE_WAKE) ||
                 (mode_nxt == adc_mode_pkg::MODE_RUN) ||
                 (mode_nxt == adc_mode_pkg::MODE_SETTLE);
    cal_act_nxt = (mode_nxt == adc_mode_pkg::MODE_SETTLE) && cal_nxt;
    dwell_nxt = (mode_nxt == mode_r) ? dwell_r + TW'(1) : '0;
  end

  // Mode sequencer registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= adc_mode_pkg::MODE_OFF;
      tmr_r <= '0;
      hi_r <= '0;
      dwell_r <= '0;
      pd_low_r <= '0;
      sclks_r <= '0;
      sclk_d_r <= 1'b0;
      cal_r <= 1'b0;
      pd_short_r <= 1'b0;
      drdy_r <= 1'b1;
      settled_r <= 1'b0;
      analog_r <= 1'b0;
      cal_act_r <= 1'b0;
      gain_r <= '0;
      mux_r <= '0;
      src_r <= '0;
      fast_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      tmr_r <= tmr_nxt;
      hi_r <= hi_nxt;
      dwell_r <= dwell_nxt;
      pd_low_r <= pd_low_nxt;
      sclks_r <= sclks_nxt;
      sclk_d_r <= sclk_s;
      cal_r <= cal_nxt;
      pd_short_r <= pd_short_nxt;
      drdy_r <= drdy_nxt;
      settled_r <= settled_nxt;
      analog_r <= analog_nxt;
      cal_act_r <= cal_act_nxt;
      gain_r <= gain_nxt;
      mux_r <= mux_nxt;
      src_r <= src_nxt;
      fast_r <= fast_nxt;
    end
  end

  // Bus slave: zero wait states, read data registered in address phase
  always_comb begin
    ctrl_nxt = ctrl_r;
    hrdata_nxt = hrdata_r;
    wr_pend_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    pd_short_clr = 1'b0;
    if (wr_pend_r) begin
      if (wr_addr_r == adc_mode_pkg::OFS_CTRL) begin
        ctrl_nxt = {26'h0, hwdata[5:0]};
      end else if (wr_addr_r == adc_mode_pkg::OFS_STATUS) begin
        pd_short_clr = hwdata[adc_mode_pkg::ST_PDSHORT];
      end
    end
    if (hsel && hready && htrans[1]) begin
      wr_pend_nxt = hwrite;
      wr_addr_nxt = {haddr[7:2], 2'h0};
      if (!hwrite) begin
        unique case ({haddr[7:2], 2'h0})
          adc_mode_pkg::OFS_CTRL: hrdata_nxt = ctrl_r;
          adc_mode_pkg::OFS_STATUS: hrdata_nxt = {18'h0, sclks_r,
            pd_short_r, src_r, cal_act_r, analog_r, drdy_r, mode_r};
          default: hrdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  // Bus registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= adc_mode_pkg::CTRL_RST;
      hrdata_r <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hreadyout_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      hrdata_r <= hrdata_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hreadyout_r <= 1'b1;
    end
  end

  // Outputs straight from flops, except hresp tied low
  assign ready_and_result_out = drdy_r;
  assign analog_on = analog_r;
  assign offset_cal_active = cal_act_r;
  assign result_settled = settled_r;
  assign pga_gain = gain_r;
  assign mux_channel = mux_r;
  assign rate_fast = fast_r;
  assign clock_source = src_r;
  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_pd_hold;
    !pd_n_s |=> mode_r == adc_mode_pkg::MODE_OFF && !analog_r;
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("pd not held");

  property p_pd_clear;
    !pd_n_s ##1 !pd_n_s |-> sclks_r == '0 && !cal_r && drdy_r;
  endproperty
  a_pd_clear: assert property (p_pd_clear) else $error("pd no clear");

  property p_cal_req;
    mode_r == adc_mode_pkg::MODE_RUN && pd_n_s && sclk_s &&
      hi_r == act_cyc - TW'(1) && sclks_r == adc_mode_pkg::SCLK_CAL_CNT + 5'h01
      |=> mode_r == adc_mode_pkg::MODE_STBY && cal_r;
  endproperty
  a_cal_req: assert property (p_cal_req) else $error("cal not set");

  property p_stby_time;
    mode_r == adc_mode_pkg::MODE_RUN && hi_r < act_cyc - TW'(1)
      |=> mode_r != adc_mode_pkg::MODE_STBY;
  endproperty
  a_stby_time: assert property (p_stby_time) else $error("early stby");

  property p_settle_len;
    mode_r == adc_mode_pkg::MODE_SETTLE && pd_n_s && tmr_r == '0
      |-> dwell_r == settle_cyc - TW'(1) ##1 !drdy_r &&
        settled_r == $past(cal_r);
  endproperty
  a_settle_len: assert property (p_settle_len) else $error("settle len");

  property p_cal_drdy;
    mode_r == adc_mode_pkg::MODE_SETTLE |-> drdy_r && cal_act_r == cal_r;
  endproperty
  a_cal_drdy: assert property (p_cal_drdy) else $error("drdy in cal");

  property p_wake_len;
    mode_r == adc_mode_pkg::MODE_WAKE && pd_n_s && tmr_r == '0
      |-> dwell_r + TW'(1) == (src_r == adc_mode_pkg::CLK_XTAL ?
        TW'(WAKE_XTAL) : src_r == adc_mode_pkg::CLK_EXT ?
        TW'(adc_mode_pkg::CYC_WAKE_EXT) : TW'(adc_mode_pkg::CYC_WAKE_INT));
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake len");

  property p_short_pd;
    mode_r == adc_mode_pkg::MODE_OFF && pd_n_s &&
      pd_low_r < PDW'(adc_mode_pkg::CYC_PD_MIN) |=> pd_short_r;
  endproperty
  a_short_pd: assert property (p_short_pd) else $error("short pd");

  property p_straps;
    mode_r == adc_mode_pkg::MODE_OFF && pd_n_s &&
      !ctrl_r[adc_mode_pkg::CTRL_OVR] && gain_s == 2'h3 && !chan_s &&
      !temp_s && !rate_s |=> gain_r == adc_mode_pkg::GAIN_128 &&
      mux_r == adc_mode_pkg::MUX_CH1 && !fast_r;
  endproperty
  a_straps: assert property (p_straps) else $error("strap decode");

  property p_wake_stby;
    mode_r == adc_mode_pkg::MODE_STBY && pd_n_s && !sclk_s
      |=> mode_r == adc_mode_pkg::MODE_SETTLE && analog_r;
  endproperty
  a_wake_stby: assert property (p_wake_stby) else $error("no wake");

endmodule : adc_power_mode_control

// ===== verif/host_model.sv
// Host side model: drives the serial clock and power-down pins.
// Assumes core_clk as timebase; pins change just after rising edges.
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic core_clk,
  // Pins towards the converter
  output logic sclk,
  output logic power_down_n_pin
);
  // Each level held long enough to pass the pin filter
  localparam int HOLD = 6;

  // Pins start low, as at supply ramp
  initial begin
    sclk = 1'b0;
    power_down_n_pin = 1'b0;
  end

  // Serial clock pulses, then park high or low
  task automatic pulses(input int n, input bit park);
    @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b1;
      repeat (HOLD) @(posedge core_clk);
      sclk <= 1'b0;
      repeat (HOLD) @(posedge core_clk);
    end
    sclk <= park;
    @(posedge core_clk);
  endtask : pulses

  // Power-down pin level
  task automatic set_pd(input bit v);
    @(posedge core_clk);
    power_down_n_pin <= v;
  endtask : set_pd

  // Low after supplies, then high, low, high toggle
  task automatic power_up();
    @(posedge core_clk);
    power_down_n_pin <= 1'b0;
    repeat (1000) @(posedge core_clk);
    power_down_n_pin <= 1'b1;
    repeat (2600) @(posedge core_clk);
    power_down_n_pin <= 1'b0;
    repeat (2600) @(posedge core_clk);
    power_down_n_pin <= 1'b1;
  endtask : power_up
endmodule : host_model

// ===== verif/adc_power_mode_control_tb.sv
// Self-checking bench for the power and mode controller.
// Assumes host_model on the pins and a single AHB-Lite master here.
`timescale 1ns/1ps
module adc_power_mode_control_tb;
  // Shortened counts; expectations derive from these
  localparam int ACT_F = 200, ACT_S = 300, CAL_F = 400, CAL_S = 500;
  // Conversion period outlasts 25 pulses plus the standby hold
  localparam int NCAL_F = 150, NCAL_S = 250, CONV_F = 600, CONV_S = 700;
  localparam int WXT = 60, TOL = 10;
  logic core_clk, nrst, sclk, power_down_n_pin;
  logic [1:0] gain_select;
  logic channel_select, temp_select, rate_select;
  logic clock_input_grounded, crystal_output_open;
  logic ready_and_result_out, analog_on, offset_cal_active;
  logic result_settled, rate_fast, hsel, hwrite, hreadyout, hresp;
  logic [1:0] pga_gain, mux_channel, clock_source, htrans, src;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, lfsr;
  logic rate, cal;
  int error_cnt, checks, n, lo, ex;

  host_model u_host (.core_clk(core_clk), .sclk(sclk),
    .power_down_n_pin(power_down_n_pin));
  adc_power_mode_control #(.ACT_FAST(ACT_F), .ACT_SLOW(ACT_S),
    .CAL_FAST(CAL_F), .CAL_SLOW(CAL_S), .NOCAL_FAST(NCAL_F),
    .NOCAL_SLOW(NCAL_S), .CONV_FAST(CONV_F), .CONV_SLOW(CONV_S),
    .WAKE_XTAL(WXT)) u_dut (.core_clk(core_clk), .nrst(nrst),
    .sclk(sclk), .power_down_n_pin(power_down_n_pin),
    .gain_select(gain_select), .channel_select(channel_select),
    .temp_select(temp_select), .rate_select(rate_select),
    .clock_input_grounded(clock_input_grounded),
    .crystal_output_open(crystal_output_open),
    .ready_and_result_out(ready_and_result_out), .analog_on(analog_on),
    .offset_cal_active(offset_cal_active),
    .result_settled(result_settled), .pga_gain(pga_gain),
    .mux_channel(mux_channel), .rate_fast(rate_fast),
    .clock_source(clock_source), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp));

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Pseudo-random strap values
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  // Expected wake delay by clock source
  function automatic int exp_wake(input logic [1:0] s);
    if (s == 2'h0) return adc_mode_pkg::CYC_WAKE_INT;
    if (s == 2'h1) return adc_mode_pkg::CYC_WAKE_EXT;
    return WXT;
  endfunction : exp_wake

  // Sync delay makes cycle figures approximate
  function automatic bit near(input int m, input int e);
    return (m >= e - TOL) && (m <= e + TOL);
  endfunction : near

  task automatic chk(input bit ok, input string m);
    checks++;
    if (!ok) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk

  // One single AHB-Lite transfer; waits on hready
  task automatic bus(input bit w, input logic [31:0] a, d,
                     output logic [31:0] r);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk(hresp === 1'b0, "response not okay");
  endtask : bus

  // Cycles until data ready goes low, sampled mid-cycle
  task automatic wait_ready(output int c);
    c = 0;
    while (ready_and_result_out !== 1'b0 && c < 20000) begin
      @(negedge core_clk);
      c++;
    end
  endtask : wait_ready

  task automatic results();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  // Hang guard, well beyond the expected run
  initial begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    $display("CHECK FAILED %0t timeout", $time);
    results();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {gain_select, channel_select, temp_select, rate_select} = '0;
    clock_input_grounded = 1'b1;
    crystal_output_open = 1'b0;
    error_cnt = 0;
    checks = 0;
    lfsr = 32'ha3b4;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    hsize <= 3'h2;
    u_host.power_up();
    bus(1'b1, 32'h4, 32'h100, rd);
    bus(1'b1, 32'h0, 32'hffff_fffe, rd);
    bus(1'b0, 32'h0, 32'h0, rd);
    chk(rd === 32'h3e, "control readback");
    bus(1'b1, 32'h0, 32'h0, rd);
    bus(1'b0, 32'h8, 32'h0, rd);
    chk(rd === 32'h0, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      src = 2'(i % 3);
      rate = i[0];
      cal = (i != 1);
      lo = (i == 2) ? 100 : 2700;
      // Power-down while a readout is under way
      u_host.pulses(3, 1'b1);
      u_host.set_pd(1'b0);
      @(posedge core_clk);
      gain_select <= lfsr[1:0];
      channel_select <= lfsr[2];
      temp_select <= lfsr[3];
      rate_select <= rate;
      clock_input_grounded <= (src == 2'h0);
      crystal_output_open <= (src == 2'h1);
      u_host.pulses(0, 1'b0);
      repeat (lo) @(posedge core_clk);
      bus(1'b0, 32'h4, 32'h0, rd);
      chk(rd[2:0] === 3'h0 && analog_on === 1'b0, "not powered down");
      chk(ready_and_result_out === 1'b1 && offset_cal_active === 1'b0
        && result_settled === 1'b0, "state not cleared");
      if (i == 3) bus(1'b1, 32'h0, 32'h2b, rd);
      u_host.set_pd(1'b1);
      wait_ready(n);
      ex = exp_wake(src) + (rate ? CONV_F : CONV_S);
      chk(near(n, ex), "wake delay");
      // Last pass takes gain, mux and rate from the control override
      ex = (i == 3) ? 1 : lfsr[3] ? 2 : (lfsr[2] ? 1 : 0);
      chk(pga_gain === ((i == 3) ? 2'h1 : lfsr[1:0])
        && mux_channel === 2'(ex)
        && rate_fast === rate, "gain mux rate");
      chk(clock_source === src, "clock source");
      bus(1'b0, 32'h4, 32'h0, rd);
      chk(rd[8] === (i == 2), "short pulse flag");
      bus(1'b1, 32'h4, 32'h100, rd);
      // Standby, with or without calibration request
      u_host.pulses(cal ? 25 : 24, 1'b1);
      repeat ((rate ? ACT_F : ACT_S) - TOL) @(posedge core_clk);
      bus(1'b0, 32'h4, 32'h0, rd);
      chk(rd[2:0] === 3'h2, "standby too early");
      repeat (2 * TOL) @(posedge core_clk);
      bus(1'b0, 32'h4, 32'h0, rd);
      chk(rd[2:0] === 3'h3 && analog_on === 1'b0
        && ready_and_result_out === 1'b1, "standby missing");
      u_host.pulses(0, 1'b0);
      repeat (50) @(negedge core_clk);
      chk(offset_cal_active === cal && ready_and_result_out === 1'b1,
        "calibration state");
      wait_ready(n);
      if (cal)
        ex = rate ? CAL_F : CAL_S;
      else
        ex = rate ? NCAL_F : NCAL_S;
      chk(near(n + 51, ex), "ready after standby");
      chk(result_settled === cal, "settled flag");
    end
    results();
  end
endmodule : adc_power_mode_control_tb
